// file: hw/fcr_pkg.sv
// Purpose: shared constants and types for the command fifo block
// Assumes: 100 MHz core clock, byte-wide data fifo
// Notes: command and response share one byte buffer
package fcr_pkg;
    localparam int ADDR_W = 11;
    localparam int CNT_W = ADDR_W + 1;
    localparam int BURST_W = 16;
    localparam int LOC_W = 3;
    localparam logic [CNT_W-1:0] CMD_DEPTH = 12'h800;
    // command header: size field is bytes 2..5, big endian, inside first 10 bytes
    localparam logic [CNT_W-1:0] SIZE_FIRST = 12'h002;
    localparam logic [CNT_W-1:0] SIZE_LAST = 12'h005;
    localparam logic [CNT_W-1:0] SIZE_KNOWN = 12'h006;
    localparam logic [CNT_W-1:0] HDR_LEN = 12'h00a;
    localparam logic [7:0] IDLE_READ_BYTE = 8'hff;
    localparam logic [BURST_W-1:0] BURST_NONE = 16'h0000;
    // abort limits
    localparam int CLK_KHZ = 100000;
    localparam int TIMEOUT_A_MS = 750;
    localparam int TIMEOUT_B_MS = 2000;
    localparam int TIMEOUT_A_CYC = TIMEOUT_A_MS * CLK_KHZ;
    localparam int TIMEOUT_B_CYC = TIMEOUT_B_MS * CLK_KHZ;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PREP = 3'h1,
        ST_READY = 3'h3,
        ST_RECV = 3'h2,
        ST_HELD = 3'h6,
        ST_EXEC = 3'h7,
        ST_RESP = 3'h5,
        ST_ABORT = 3'h4
    } fcr_state_t;

    typedef struct packed {
        logic cmd_ready_flag;
        logic expect_more;
        logic response_available;
        logic [BURST_W-1:0] fifo_burst_depth;
    } fcr_status_t;

    // oversized size fields are clamped to the buffer, undersized ones to the header length
    function automatic logic [CNT_W-1:0] fcr_cmd_len(input logic [31:0] size);
        logic [CNT_W-1:0] len;
        if (size < {20'h00000, HDR_LEN})
            len = HDR_LEN;
        else if (size > {20'h00000, CMD_DEPTH})
            len = CMD_DEPTH;
        else
            len = size[CNT_W-1:0];
        return len;
    endfunction

    function automatic logic [BURST_W-1:0] fcr_burst(input logic [CNT_W-1:0] hi, input logic [CNT_W-1:0] lo);
        logic [CNT_W-1:0] diff;
        diff = hi - lo;
        return {4'h0, diff};
    endfunction
endpackage

// file: hw/fcr_byte_ram.sv
// Purpose: byte buffer for command and response data
// Assumes: one write port, one read port, same clock
// Notes: read data is registered, one cycle after the address
module fcr_byte_ram
    import fcr_pkg::*;
(
    input wire logic clk,
    input wire logic we,
    input wire logic [ADDR_W-1:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [ADDR_W-1:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [0:(1<<ADDR_W)-1];

    always_ff @(posedge clk)
    begin
        if (we)
            mem[waddr] <= wdata;
        rdata <= mem[raddr];
    end
endmodule

// file: hw/fcr_abort_timer.sv
// Purpose: bounds the time an executing command may take to abort
// Assumes: start is a pulse, run is held while the abort is pending
// Notes: limit picked at start from the command duration class
module fcr_abort_timer
    import fcr_pkg::*;
#(
    parameter int TA_CYC = TIMEOUT_A_CYC,
    parameter int TB_CYC = TIMEOUT_B_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic long_cmd,
    input wire logic run,
    output logic expired
);
    logic [31:0] cnt_q;
    logic [31:0] limit_q;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_q <= 32'h0;
            limit_q <= 32'h0;
            expired <= 1'b0;
        end
        else if (start)
        begin
            cnt_q <= 32'h0;
            limit_q <= long_cmd ? 32'(TB_CYC - 1) : 32'(TA_CYC - 1);
            expired <= 1'b0;
        end
        else if (run && !expired)
        begin
            cnt_q <= cnt_q + 32'h1;
            expired <= (cnt_q >= limit_q);
        end
    end
endmodule

// file: hw/fcr_cmd_fifo.sv
// Purpose: command send, execute, response and abort control for a byte fifo
// Assumes: host strobes are one-cycle pulses; fifo requests held until ack
// Notes: an unanswered request is the bus wait state; writes outside receive and prep are acked and dropped
module fcr_cmd_fifo
    import fcr_pkg::*;
#(
    parameter int TA_CYC = TIMEOUT_A_CYC,
    parameter int TB_CYC = TIMEOUT_B_CYC
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [LOC_W-1:0] host_loc,
    input wire logic cmd_ready_wr,
    input wire logic go_execute,
    input wire logic seize_ok,
    input wire logic locality_active_release,
    input wire logic hash_sequence_start,
    input wire logic wr_req,
    input wire logic [7:0] wr_byte,
    input wire logic rd_req,
    input wire logic [ADDR_W-1:0] eng_rd_addr,
    input wire logic rsp_wr,
    input wire logic [7:0] rsp_byte,
    input wire logic exec_done,
    input wire logic exec_long,
    input wire logic exec_halted,
    output fcr_status_t status_reg,
    output logic wr_ack,
    output logic rd_ack,
    output logic [7:0] rd_byte,
    output logic exec_start,
    output logic exec_abort,
    output logic [CNT_W-1:0] cmd_len,
    output logic [LOC_W-1:0] cmd_loc,
    output logic [7:0] eng_rd_data,
    output logic abort_late
);
    fcr_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] ptr_q, ptr_d;
    logic [31:0] size_q, size_d;
    logic [LOC_W-1:0] loc_q, loc_d;
    logic [CNT_W-1:0] len_q, len_d;
    fcr_status_t status_q, status_d;
    logic wr_ack_q, rd_pend_q, rd_dummy_q, rd_ack_q;
    logic [7:0] rd_byte_q;
    logic exec_start_q, exec_start_d;
    logic exec_abort_q, exec_abort_d;
    logic late_q, late_d;
    logic [7:0] mem_rdata;
    logic timer_expired;

    // decode of the current cycle
    wire any_abort = seize_ok | locality_active_release | hash_sequence_start;
    wire rx_state = (state_q == ST_READY) || (state_q == ST_RECV);
    wire size_known = cnt_q >= SIZE_KNOWN;
    wire [CNT_W-1:0] exp_len = fcr_cmd_len(size_q);
    wire rx_complete = (state_q == ST_RECV) && size_known && (cnt_q >= exp_len);
    wire wr_free = wr_req && !wr_ack_q;
    // full buffer or prep: leave the request unanswered (wait state)
    wire wr_take = wr_free && rx_state && !rx_complete && (cnt_q < CMD_DEPTH);
    wire wr_drop = wr_free && !rx_state && (state_q != ST_PREP);
    wire rd_free = rd_req && !rd_pend_q && !rd_dummy_q && !rd_ack_q;
    wire loc_ok = host_loc == loc_q;
    wire loc_mismatch = (state_q == ST_RESP) && rd_req && !loc_ok;
    wire rd_issue = rd_free && (state_q == ST_RESP) && loc_ok && (ptr_q < cnt_q);
    wire rd_dummy = rd_free && !rd_issue;
    wire rsp_take = (state_q == ST_EXEC) && rsp_wr && (cnt_q < CMD_DEPTH);
    wire last_read = (state_q == ST_RESP) && rd_pend_q && (ptr_q == cnt_q);
    wire abort_start = (state_q == ST_EXEC) && (cmd_ready_wr || any_abort);
    wire mem_we = wr_take || rsp_take;
    wire [7:0] mem_wdata = (state_q == ST_EXEC) ? rsp_byte : wr_byte;
    wire [ADDR_W-1:0] mem_raddr = (state_q == ST_EXEC) ? eng_rd_addr : ptr_q[ADDR_W-1:0];

    fcr_byte_ram u_ram (
        .clk(clk),
        .we(mem_we),
        .waddr(cnt_q[ADDR_W-1:0]),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    fcr_abort_timer #(
        .TA_CYC(TA_CYC),
        .TB_CYC(TB_CYC)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .start(abort_start),
        .long_cmd(exec_long),
        .run(state_q == ST_ABORT),
        .expired(timer_expired)
    );

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        ptr_d = ptr_q;
        size_d = size_q;
        loc_d = loc_q;
        len_d = len_q;
        exec_start_d = 1'b0;
        exec_abort_d = 1'b0;
        late_d = late_q;
        case (state_q)
            ST_IDLE:
            begin
                if (cmd_ready_wr)
                    state_d = ST_PREP;
            end
            ST_PREP:
            begin
                // clear the buffer before offering it to the host
                cnt_d = '0;
                ptr_d = '0;
                size_d = 32'h0;
                state_d = ST_READY;
            end
            ST_READY, ST_RECV:
            begin
                if (cmd_ready_wr && state_q == ST_RECV)
                    state_d = ST_PREP;
                else if (any_abort)
                    state_d = ST_IDLE;
                else if (rx_complete)
                    state_d = ST_HELD;
                else if (wr_take)
                begin
                    cnt_d = cnt_q + 12'h001;
                    state_d = ST_RECV;
                    if (state_q == ST_READY)
                        loc_d = host_loc;
                    if (cnt_q >= SIZE_FIRST && cnt_q <= SIZE_LAST)
                        size_d = {size_q[23:0], wr_byte};
                end
            end
            ST_HELD:
            begin
                if (cmd_ready_wr)
                    state_d = ST_PREP;
                else if (any_abort)
                    state_d = ST_IDLE;
                else if (go_execute)
                begin
                    state_d = ST_EXEC;
                    exec_start_d = 1'b1;
                    len_d = cnt_q;
                    cnt_d = '0;
                    late_d = 1'b0;
                end
            end
            ST_EXEC:
            begin
                if (abort_start)
                begin
                    state_d = ST_ABORT;
                    exec_abort_d = 1'b1;
                end
                else if (exec_done)
                begin
                    state_d = (cnt_d != '0 || rsp_take) ? ST_RESP : ST_IDLE;
                    ptr_d = '0;
                    if (rsp_take)
                        cnt_d = cnt_q + 12'h001;
                end
                else if (rsp_take)
                    cnt_d = cnt_q + 12'h001;
            end
            ST_RESP:
            begin
                if (cmd_ready_wr)
                    state_d = ST_PREP;
                else if (any_abort || loc_mismatch)
                    state_d = ST_IDLE;
                else if (last_read)
                    state_d = ST_IDLE;
                else if (rd_issue)
                    ptr_d = ptr_q + 12'h001;
            end
            ST_ABORT:
            begin
                // the engine commits to pre or post state before halting
                if (exec_halted || timer_expired)
                begin
                    state_d = ST_IDLE;
                    late_d = timer_expired && !exec_halted;
                end
            end
            default:
                state_d = ST_IDLE;
        endcase
        if (state_d == ST_IDLE)
        begin
            cnt_d = '0;
            ptr_d = '0;
        end
    end

    always_comb
    begin
        status_d.cmd_ready_flag = state_d == ST_READY;
        status_d.expect_more = state_d == ST_RECV;
        status_d.response_available = state_d == ST_RESP;
        if (state_d == ST_READY || state_d == ST_RECV)
            status_d.fifo_burst_depth = fcr_burst(CMD_DEPTH, cnt_d);
        else if (state_d == ST_RESP)
            status_d.fifo_burst_depth = fcr_burst(cnt_d, ptr_d);
        else
            status_d.fifo_burst_depth = BURST_NONE;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            ptr_q <= '0;
            size_q <= 32'h0;
            loc_q <= '0;
            len_q <= '0;
            status_q <= '0;
            exec_start_q <= 1'b0;
            exec_abort_q <= 1'b0;
            late_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            ptr_q <= ptr_d;
            size_q <= size_d;
            loc_q <= loc_d;
            len_q <= len_d;
            status_q <= status_d;
            exec_start_q <= exec_start_d;
            exec_abort_q <= exec_abort_d;
            late_q <= late_d;
        end
    end

    // host handshakes: a request left unanswered stalls the bus cycle
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wr_ack_q <= 1'b0;
            rd_pend_q <= 1'b0;
            rd_dummy_q <= 1'b0;
            rd_ack_q <= 1'b0;
            rd_byte_q <= 8'h00;
        end
        else
        begin
            wr_ack_q <= wr_take || wr_drop;
            rd_pend_q <= rd_issue;
            rd_dummy_q <= rd_dummy;
            rd_ack_q <= rd_pend_q || rd_dummy_q;
            if (rd_pend_q || rd_dummy_q)
                rd_byte_q <= rd_pend_q ? mem_rdata : IDLE_READ_BYTE;
        end
    end

    assign status_reg = status_q;
    assign wr_ack = wr_ack_q;
    assign rd_ack = rd_ack_q;
    assign rd_byte = rd_byte_q;
    assign exec_start = exec_start_q;
    assign exec_abort = exec_abort_q;
    assign cmd_len = len_q;
    assign cmd_loc = loc_q;
    assign eng_rd_data = mem_rdata;
    assign abort_late = late_q;

    sequence s_ready_req;
        state_q == ST_IDLE && cmd_ready_wr;
    endsequence

    sequence s_offer;
        status_q.cmd_ready_flag && status_q.fifo_burst_depth != BURST_NONE;
    endsequence

    sequence s_first_byte;
        state_q == ST_READY && wr_take && !any_abort;
    endsequence

    chk_ready_offer: assert property (@(posedge clk) disable iff (rst) s_ready_req |-> ##2 s_offer)
        else $error("command-ready not offered two cycles after request");

    chk_first_byte: assert property (@(posedge clk) disable iff (rst)
        s_first_byte |=> (status_q.expect_more && !status_q.cmd_ready_flag))
        else $error("first byte did not move ready to expect");

    chk_expect_drop: assert property (@(posedge clk) disable iff (rst)
        (rx_complete && !cmd_ready_wr && !any_abort) |=> !status_q.expect_more && state_q == ST_HELD)
        else $error("expect not cleared after last command byte");

    chk_go_ignored: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_RECV && go_execute) |=> !exec_start_q)
        else $error("go accepted while expect set");

    chk_go_start: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_HELD && go_execute && !cmd_ready_wr && !any_abort) |=> exec_start_q && cmd_len == $past(cnt_q))
        else $error("go did not start execution");

    chk_resp_flag: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_EXEC && exec_done && !abort_start && cnt_q != '0)
        |=> status_q.response_available
        && status_q.fifo_burst_depth == fcr_burst($past(cnt_q) + CNT_W'($past(rsp_take)), '0))
        else $error("response not flagged on completion");

    chk_resp_clear: assert property (@(posedge clk) disable iff (rst)
        (last_read && !cmd_ready_wr && !any_abort) |=> !status_q.response_available && rd_ack_q)
        else $error("response flag left set after last read");

    chk_abort_idle: assert property (@(posedge clk) disable iff (rst)
        (any_abort && !cmd_ready_wr && state_q inside {ST_RECV, ST_HELD, ST_RESP})
        |=> state_q == ST_IDLE && status_q == '0)
        else $error("abort did not return to idle with flags clear");

    chk_abort_bound: assert property (@(posedge clk) disable iff (rst)
        (state_q == ST_ABORT && timer_expired) |=> state_q == ST_IDLE && abort_late == !$past(exec_halted))
        else $error("abort exceeded its time limit");

    chk_full_wait: assert property (@(posedge clk) disable iff (rst)
        (wr_req && rx_state && cnt_q == CMD_DEPTH && !wr_ack_q) |=> !wr_ack_q)
        else $error("write acknowledged into a full buffer");

    chk_loc_guard: assert property (@(posedge clk) disable iff (rst)
        loc_mismatch |-> !rd_issue ##1 state_q inside {ST_IDLE, ST_PREP} ##1 !rd_pend_q)
        else $error("response offered to another locality");
endmodule

// file: tb/fcr_cmd_fifo_tb_top.sv
// Purpose: self-checking bench for the command fifo control block
// Assumes: abort limits shortened to 20 and 40 cycles; bench plays host and engine
// Notes: inputs change on the falling edge only
module fcr_cmd_fifo_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import fcr_pkg::*;

    localparam int TA = 20;
    localparam int TB = 40;

    logic clk, rst, cmd_ready_wr, go_execute, seize_ok, locality_active_release, hash_sequence_start;
    logic wr_req, rd_req, rsp_wr, exec_done, exec_long, exec_halted;
    logic wr_ack, rd_ack, exec_start, exec_abort, abort_late;
    logic [LOC_W-1:0] host_loc, cmd_loc;
    logic [7:0] wr_byte, rsp_byte, rd_byte, eng_rd_data, got;
    logic [ADDR_W-1:0] eng_rd_addr;
    logic [CNT_W-1:0] cmd_len;
    fcr_status_t status_reg;
    int n_errors = 0;
    int checks = 0;

    fcr_cmd_fifo #(.TA_CYC(TA), .TB_CYC(TB)) u_dut (.clk(clk), .rst(rst), .host_loc(host_loc),
        .cmd_ready_wr(cmd_ready_wr), .go_execute(go_execute), .seize_ok(seize_ok),
        .locality_active_release(locality_active_release), .hash_sequence_start(hash_sequence_start),
        .wr_req(wr_req), .wr_byte(wr_byte), .rd_req(rd_req), .eng_rd_addr(eng_rd_addr), .rsp_wr(rsp_wr),
        .rsp_byte(rsp_byte), .exec_done(exec_done), .exec_long(exec_long), .exec_halted(exec_halted),
        .status_reg(status_reg), .wr_ack(wr_ack), .rd_ack(rd_ack), .rd_byte(rd_byte),
        .exec_start(exec_start), .exec_abort(exec_abort), .cmd_len(cmd_len), .cmd_loc(cmd_loc),
        .eng_rd_data(eng_rd_data), .abort_late(abort_late));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        checks++;
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            n_errors++;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // size field big endian at bytes 2..5, other bytes a marker pattern
    function automatic logic [7:0] cmd_byte(input int i, input int n);
        logic [31:0] sz;
        sz = n;
        case (i)
            2: return sz[31:24];
            3: return sz[23:16];
            4: return sz[15:8];
            5: return sz[7:0];
            default: return 8'(i) ^ 8'h5a;
        endcase
    endfunction

    // 0 ready 1 go 2 seize 3 release 4 hash 5 done 6 halted
    task automatic pulse(input int which);
        @(negedge clk);
        case (which)
            0: cmd_ready_wr = 1'b1;
            1: go_execute = 1'b1;
            2: seize_ok = 1'b1;
            3: locality_active_release = 1'b1;
            4: hash_sequence_start = 1'b1;
            5: exec_done = 1'b1;
            default: exec_halted = 1'b1;
        endcase
        @(negedge clk);
        {cmd_ready_wr, go_execute, seize_ok, locality_active_release, hash_sequence_start} = 5'h00;
        {exec_done, exec_halted} = 2'h0;
    endtask

    task automatic wr(input logic [7:0] b);
        int k;
        @(negedge clk);
        wr_req = 1'b1;
        wr_byte = b;
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end while (wr_ack !== 1'b1 && k < 20);
        wr_req = 1'b0;
        chk("wr_ack", 16'h0001, {15'h0000, wr_ack});
    endtask

    task automatic rd(output logic [7:0] b);
        int k;
        @(negedge clk);
        rd_req = 1'b1;
        k = 0;
        do
        begin
            @(negedge clk);
            k++;
        end while (rd_ack !== 1'b1 && k < 20);
        rd_req = 1'b0;
        b = rd_byte;
        chk("rd_ack", 16'h0001, {15'h0000, rd_ack});
    endtask

    task automatic prep();
        int k;
        pulse(0);
        k = 0;
        while (status_reg.cmd_ready_flag !== 1'b1 && k < 8)
        begin
            @(negedge clk);
            k++;
        end
        chk("ready", 16'h0001, {15'h0000, status_reg.cmd_ready_flag});
        chk("burst", 16'h0800, status_reg.fifo_burst_depth);
    endtask

    task automatic send(input int n, input int upto, input logic [LOC_W-1:0] loc);
        host_loc = loc;
        prep();
        for (int i = 0; i < upto; i++)
            wr(cmd_byte(i, n));
    endtask

    task automatic test_full_cycle();
        send(12, 1, 3'h0);
        chk("ready", 16'h0000, {15'h0000, status_reg.cmd_ready_flag});
        chk("expect", 16'h0001, {15'h0000, status_reg.expect_more});
        chk("burst", 16'h07ff, status_reg.fifo_burst_depth);
        for (int i = 1; i < 11; i++)
            wr(cmd_byte(i, 12));
        chk("expect", 16'h0001, {15'h0000, status_reg.expect_more});
        pulse(1);
        chk("exec_start", 16'h0000, {15'h0000, exec_start});
        wr(cmd_byte(11, 12));
        repeat (2) @(negedge clk);
        chk("expect", 16'h0000, {15'h0000, status_reg.expect_more});
        wr(8'h33);
        chk("burst", 16'h0000, status_reg.fifo_burst_depth);
        pulse(1);
        chk("exec_start", 16'h0001, {15'h0000, exec_start});
        chk("cmd_len", 16'h000c, {4'h0, cmd_len});
        eng_rd_addr = 11'h005;
        @(negedge clk);
        chk("eng_rd_data", 16'h000c, {8'h00, eng_rd_data});
        for (int i = 0; i < 3; i++)
        begin
            @(negedge clk);
            rsp_wr = 1'b1;
            rsp_byte = 8'ha0 + 8'(i);
        end
        @(negedge clk);
        rsp_wr = 1'b0;
        pulse(5);
        chk("avail", 16'h0001, {15'h0000, status_reg.response_available});
        chk("burst", 16'h0003, status_reg.fifo_burst_depth);
        chk("burst_open", 16'h0001, {15'h0000, status_reg.fifo_burst_depth != BURST_NONE});
        for (int i = 0; i < 3; i++)
        begin
            rd(got);
            chk("rd_byte", {8'h00, 8'ha0 + 8'(i)}, {8'h00, got});
            chk("burst", 16'(2 - i), status_reg.fifo_burst_depth);
        end
        chk("avail", 16'h0000, {15'h0000, status_reg.response_available});
        $display("test full_cycle done");
    endtask

    task automatic test_recv_aborts();
        send(12, 3, 3'h0);
        prep();
        chk("expect", 16'h0000, {15'h0000, status_reg.expect_more});
        wr(cmd_byte(0, 12));
        pulse(2);
        chk("status", 16'h0000, {status_reg.cmd_ready_flag, status_reg.expect_more, 14'h0000});
        chk("burst", 16'h0000, status_reg.fifo_burst_depth);
        send(12, 2, 3'h0);
        pulse(4);
        chk("expect", 16'h0000, {15'h0000, status_reg.expect_more});
        chk("burst", 16'h0000, status_reg.fifo_burst_depth);
        $display("test recv_aborts done");
    endtask

    task automatic abort_exec(input int src, input logic lng, input logic halt);
        int k;
        send(10, 10, 3'h0);
        repeat (2) @(negedge clk);
        pulse(1);
        exec_long = lng;
        pulse(src);
        k = 0;
        while (exec_abort !== 1'b1 && k < 3)
        begin
            @(negedge clk);
            k++;
        end
        chk("exec_abort", 16'h0001, {15'h0000, exec_abort});
        if (halt)
        begin
            pulse(6);
            chk("abort_late", 16'h0000, {15'h0000, abort_late});
        end
        else
        begin
            while (abort_late !== 1'b1 && k < 100)
            begin
                @(negedge clk);
                k++;
            end
            chk("abort_late", 16'h0001, {15'h0000, abort_late});
            chk("abort_short", 16'h0001, {15'h0000, lng || k <= TA + 3});
            chk("abort_long", 16'h0001, {15'h0000, !lng || (k > TA + 2 && k <= TB + 3)});
        end
        exec_long = 1'b0;
        chk("status", 16'h0000, {status_reg.cmd_ready_flag, status_reg.response_available, 14'h0000});
        $display("test abort_exec %0d done", src);
    endtask

    task automatic test_wrong_locality();
        send(10, 10, 3'h1);
        repeat (2) @(negedge clk);
        pulse(1);
        chk("cmd_loc", 16'h0001, {13'h0000, cmd_loc});
        @(negedge clk);
        rsp_wr = 1'b1;
        rsp_byte = 8'h77;
        @(negedge clk);
        rsp_wr = 1'b0;
        pulse(5);
        host_loc = 3'h2;
        rd(got);
        chk("rd_byte", 16'h00ff, {8'h00, got});
        chk("avail", 16'h0000, {15'h0000, status_reg.response_available});
        host_loc = 3'h0;
        $display("test wrong_locality done");
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        finish_test();
    end

    initial
    begin
        rst = 1'b1;
        host_loc = 3'h0;
        {cmd_ready_wr, go_execute, seize_ok, locality_active_release, hash_sequence_start} = 5'h00;
        {wr_req, rd_req, rsp_wr, exec_done, exec_long, exec_halted} = 6'h00;
        wr_byte = 8'h00;
        rsp_byte = 8'h00;
        eng_rd_addr = 11'h000;
        repeat (5) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        test_full_cycle();
        test_recv_aborts();
        abort_exec(0, 1'b0, 1'b1);
        abort_exec(2, 1'b0, 1'b0);
        abort_exec(3, 1'b1, 1'b0);
        abort_exec(4, 1'b1, 1'b1);
        test_wrong_locality();
        finish_test();
    end
endmodule
